// ==== verilog/pec_pkg.sv ====
// Shared constants for the performance event counters and their firmware end.
// Assumes both ends run on one 50 MHz clock with a synchronous reset.
package pec_pkg;

	// ************************************************************
	// Counter widths and limits
	// ************************************************************
	localparam int          CW              = 20;
	localparam logic [19:0] CTR_MAX         = 20'hF_FFFF;
	localparam logic [19:0] CTR0_WR_MAX     = 20'hF_FFF0;
	localparam logic [19:0] CTR1_WR_MAX     = 20'hF_FFFC;
	localparam logic [19:0] CTR_RESET       = 20'h0_0000;
	localparam logic [5:0]  RET_ADD_MAX     = 6'h08;
	localparam int          RET_SLOTS       = 11;
	localparam int          FETCH_SLOTS     = 4;
	localparam int          BCACHE_SHIFT    = 3;
	localparam logic [5:0]  RD_QUIRK0_MAX   = 6'h04;

	// ************************************************************
	// Mode and input select codes
	// ************************************************************
	localparam logic       MODE_AGGREGATE  = 1'b0;
	localparam logic       MODE_SAMPLING   = 1'b1;
	localparam logic [1:0] SEL_RET_CYC     = 2'h0;
	localparam logic [1:0] SEL_CYC_NONE    = 2'h1;
	localparam logic [1:0] SEL_RET_BCACHE  = 2'h2;
	localparam logic [1:0] SEL_CYC_REPLAY  = 2'h3;

	// ************************************************************
	// Internal register selects and field positions
	// ************************************************************
	localparam logic [2:0] IPR_CTR0        = 3'h0;
	localparam logic [2:0] IPR_CTR1        = 3'h1;
	localparam logic [2:0] IPR_CTL         = 3'h2;
	localparam logic [2:0] IPR_ICTL        = 3'h3;
	localparam logic [2:0] IPR_PROCESS_CONTEXT        = 3'h4;
	localparam logic [2:0] IPR_IER         = 3'h5;
	localparam logic [2:0] IPR_HWCLR       = 3'h6;
	localparam int         CTL_MODE_BIT    = 4;
	localparam int         CTL_SEL_LSB     = 2;
	localparam int         ICTL_SYS_BIT    = 0;
	localparam int         ICTL_EN0_BIT    = 1;
	localparam int         ICTL_EN1_BIT    = 2;
	localparam int         PROCESS_CONTEXT_PROC_BIT   = 0;

	// ************************************************************
	// Firmware end APB register offsets
	// ************************************************************
	localparam logic [7:0] OFF_CTR0        = 8'h00;
	localparam logic [7:0] OFF_CTR1        = 8'h04;
	localparam logic [7:0] OFF_CTL         = 8'h08;
	localparam logic [7:0] OFF_ICTL        = 8'h0C;
	localparam logic [7:0] OFF_PROCESS_CONTEXT        = 8'h10;
	localparam logic [7:0] OFF_IER         = 8'h14;
	localparam logic [7:0] OFF_HWCLR       = 8'h18;
	localparam logic [7:0] OFF_PRIV        = 8'h1C;
	localparam logic [7:0] OFF_CMD         = 8'h20;
	localparam logic [7:0] OFF_STATUS      = 8'h24;
	localparam int         CMD_INIT_BIT    = 0;
	localparam int         CMD_COLLECT_BIT = 1;
	localparam logic       PRIV_RESET      = 1'b1;

endpackage : pec_pkg

// ==== verilog/pec_if.sv ====
// Link between the counter block and the privileged firmware end.
// Assumes both parties share one clock; no clocking block is used.
`timescale 1ns/1ns
interface pec_if;
	logic        ipr_wr;
	logic [2:0]  ipr_sel;
	logic [19:0] ipr_wdata;
	logic        priv_mode;
	logic [19:0] ctr0_rdata;
	logic [19:0] ctr1_rdata;
	logic [1:0]  summary;
	logic        irq;

	modport device (
		input  ipr_wr, ipr_sel, ipr_wdata, priv_mode,
		output ctr0_rdata, ctr1_rdata, summary, irq
	);
	modport firmware (
		output ipr_wr, ipr_sel, ipr_wdata, priv_mode,
		input  ctr0_rdata, ctr1_rdata, summary, irq
	);
endinterface : pec_if

// ==== verilog/pec_counters.sv ====
// Two 20-bit performance event counters with overflow interrupt logic.
// Assumes event inputs come from logic on clock_i and the firmware end drives the link.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ns

// Overview of operation
// - Two independent writable readable 20-bit counters.
// - Mode field zero selects aggregate counting.
// - Mode field one selects instruction sampling.
// - Input select field picks aggregate events.
// - Count needs own enable plus system/process.
// - Cycle counting adds one each cycle.
// - Retires capped at eight, excess carried.
// - Squashed instructions never count as retires.
// - Enabled overflow sets interrupt summary bit.
// - Aggregate counters keep counting past overflow.
// - Counters readable at any time.
// - Firmware writes counter zero up to 2**20-16.
// - Firmware writes counter one up to 2**20-4.
// - Firmware clears counters twice at initialization.
// - Write at threshold interrupts on leaving privilege.
// - Interrupts held off in privileged mode.
// - Firmware avoids disabled counters near overflow.
// - Disabled reads may show small extra increment.
// - Cache miss count shifted three cycles late.
// - Sampling counts squashed no-ops as fetched.
// - Conditional move counts as two fetches.
// - Firmware clears counter one before collection.
module pec_counters (
	// Clock and reset.
	input  wire logic        clock_i,
	input  wire logic        srst_i,
	// Firmware link.
	pec_if.device            link,
	// Processor events.
	input  wire logic [10:0] retire_valid_i,
	input  wire logic [10:0] retire_squash_i,
	input  wire logic [3:0]  fetch_valid_i,
	input  wire logic [3:0]  fetch_conditional_move_i,
	input  wire logic        bcache_miss_i,
	input  wire logic        replay_trap_i
);

	// ************************************************************
	// Control state
	// ************************************************************
	logic [19:0] ctr0_reg;
	logic [19:0] ctr1_reg;
	logic        mode_select_field_reg;
	logic [1:0]  input_select_field_reg;
	logic        system_count_enable_reg;
	logic        counter_zero_enable_reg;
	logic        counter_one_enable_reg;
	logic        process_count_enable_reg;
	logic [1:0]  counter_irq_enable_reg;
	logic [1:0]  ovf_latch_reg;
	logic [1:0]  summary_reg;
	logic        irq_reg;
	logic        priv_prev_reg;
	logic [5:0]  ret_backlog_reg;
	logic [3:0]  conditional_move_pend_reg;
	logic [2:0]  bcache_dly_reg;
	logic [19:0] rd0_reg;
	logic [19:0] rd1_reg;

	// ************************************************************
	// Event counting
	// ************************************************************
	logic [3:0]  ret_now;
	logic [3:0]  fetch_now;
	logic [3:0]  conditional_move_now;
	logic [5:0]  ret_total;
	logic [5:0]  ret_add;
	logic        en0;
	logic        en1;
	logic [5:0]  inc0;
	logic [5:0]  inc1;
	logic [20:0] sum0;
	logic [20:0] sum1;
	logic        wr0;
	logic        wr1;
	logic [1:0]  ovf;
	logic        leave_priv;

	always_comb begin
		ret_now   = 4'h0;
		fetch_now = 4'h0;
		conditional_move_now  = 4'h0;
		for (int i = 0; i < pec_pkg::RET_SLOTS; i++) begin
			ret_now = ret_now + {3'h0, retire_valid_i[i] & ~retire_squash_i[i]};
		end
		for (int i = 0; i < pec_pkg::FETCH_SLOTS; i++) begin
			fetch_now = fetch_now + {3'h0, fetch_valid_i[i]};
			conditional_move_now  = conditional_move_now + {3'h0, fetch_valid_i[i] & fetch_conditional_move_i[i]};
		end
	end

	assign ret_total = ret_backlog_reg + {2'h0, ret_now};
	assign ret_add   = (ret_total > pec_pkg::RET_ADD_MAX) ? pec_pkg::RET_ADD_MAX : ret_total;
	assign en0 = counter_zero_enable_reg & (system_count_enable_reg | process_count_enable_reg);
	assign en1 = counter_one_enable_reg & (system_count_enable_reg | process_count_enable_reg);

	always_comb begin
		if (mode_select_field_reg == pec_pkg::MODE_SAMPLING) begin
			inc0 = {2'h0, fetch_now} + {2'h0, conditional_move_pend_reg};
			inc1 = 6'h01;
		end else begin
			case (input_select_field_reg)
				pec_pkg::SEL_RET_CYC: begin
					inc0 = ret_add;
					inc1 = 6'h01;
				end
				pec_pkg::SEL_CYC_NONE: begin
					inc0 = 6'h01;
					inc1 = 6'h00;
				end
				pec_pkg::SEL_RET_BCACHE: begin
					inc0 = ret_add;
					inc1 = {5'h00, bcache_dly_reg[pec_pkg::BCACHE_SHIFT-1]};
				end
				default: begin
					inc0 = 6'h01;
					inc1 = {5'h00, replay_trap_i};
				end
			endcase
		end
	end

	assign sum0 = {1'b0, ctr0_reg} + {15'h0000, inc0};
	assign sum1 = {1'b0, ctr1_reg} + {15'h0000, inc1};
	assign ovf  = {en1 & sum1[20], en0 & sum0[20]};
	assign wr0  = link.ipr_wr && (link.ipr_sel == pec_pkg::IPR_CTR0);
	assign wr1  = link.ipr_wr && (link.ipr_sel == pec_pkg::IPR_CTR1);
	assign leave_priv = priv_prev_reg & ~link.priv_mode;

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			ret_backlog_reg <= 6'h00;
			conditional_move_pend_reg   <= 4'h0;
			bcache_dly_reg  <= 3'h0;
		end else begin
			ret_backlog_reg <= en0 ? (ret_total - ret_add) : 6'h00;
			conditional_move_pend_reg   <= conditional_move_now;
			bcache_dly_reg  <= {bcache_dly_reg[1:0], bcache_miss_i};
		end
	end

	// ************************************************************
	// Counters
	// ************************************************************
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			ctr0_reg <= pec_pkg::CTR_RESET;
		end else if (wr0) begin
			ctr0_reg <= link.ipr_wdata;
		end else if (en0) begin
			ctr0_reg <= sum0[19:0];
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			ctr1_reg <= pec_pkg::CTR_RESET;
		end else if (wr1) begin
			ctr1_reg <= link.ipr_wdata;
		end else if (en1) begin
			ctr1_reg <= sum1[19:0];
		end
	end

	// ************************************************************
	// Control registers
	// ************************************************************
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			mode_select_field_reg    <= pec_pkg::MODE_AGGREGATE;
			input_select_field_reg   <= pec_pkg::SEL_RET_CYC;
			system_count_enable_reg  <= 1'b0;
			counter_zero_enable_reg  <= 1'b0;
			counter_one_enable_reg   <= 1'b0;
			process_count_enable_reg <= 1'b0;
			counter_irq_enable_reg   <= 2'h0;
		end else if (link.ipr_wr) begin
			case (link.ipr_sel)
				pec_pkg::IPR_CTL: begin
					mode_select_field_reg  <= link.ipr_wdata[pec_pkg::CTL_MODE_BIT];
					input_select_field_reg <= link.ipr_wdata[pec_pkg::CTL_SEL_LSB +: 2];
				end
				pec_pkg::IPR_ICTL: begin
					system_count_enable_reg <= link.ipr_wdata[pec_pkg::ICTL_SYS_BIT];
					counter_zero_enable_reg <= link.ipr_wdata[pec_pkg::ICTL_EN0_BIT];
					counter_one_enable_reg  <= link.ipr_wdata[pec_pkg::ICTL_EN1_BIT];
				end
				pec_pkg::IPR_PROCESS_CONTEXT: begin
					process_count_enable_reg <= link.ipr_wdata[pec_pkg::PROCESS_CONTEXT_PROC_BIT];
				end
				pec_pkg::IPR_IER: begin
					counter_irq_enable_reg <= link.ipr_wdata[1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ************************************************************
	// Overflow latch, summary and interrupt
	// ************************************************************
	logic [1:0] hwclr;
	logic [1:0] latch_set;
	logic [1:0] sum_set;

	assign hwclr     = (link.ipr_wr && link.ipr_sel == pec_pkg::IPR_HWCLR) ? link.ipr_wdata[1:0] : 2'h0;
	assign latch_set = {wr1 & (ctr1_reg == pec_pkg::CTR_MAX), wr0 & (ctr0_reg == pec_pkg::CTR_MAX)};
	assign sum_set   = counter_irq_enable_reg & (ovf | ({2{leave_priv}} & ovf_latch_reg));

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			ovf_latch_reg <= 2'h0;
			priv_prev_reg <= pec_pkg::PRIV_RESET;
		end else begin
			priv_prev_reg <= link.priv_mode;
			for (int i = 0; i < 2; i++) begin
				if ((i == 0) ? wr0 : wr1) begin
					ovf_latch_reg[i] <= latch_set[i];
				end else if (hwclr[i] || leave_priv) begin
					ovf_latch_reg[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			summary_reg <= 2'h0;
			irq_reg     <= 1'b0;
		end else begin
			summary_reg <= sum_set | (summary_reg & ~hwclr);
			irq_reg     <= (|summary_reg) & ~link.priv_mode;
		end
	end

	// ************************************************************
	// Read back
	// ************************************************************
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			rd0_reg <= pec_pkg::CTR_RESET;
			rd1_reg <= pec_pkg::CTR_RESET;
		end else begin
			rd0_reg <= en0 ? ctr0_reg : ctr0_reg + {14'h0000, (inc0 > pec_pkg::RD_QUIRK0_MAX) ?
				pec_pkg::RD_QUIRK0_MAX : inc0};
			rd1_reg <= en1 ? ctr1_reg : ctr1_reg + {14'h0000, inc1};
		end
	end

	assign link.ctr0_rdata = rd0_reg;
	assign link.ctr1_rdata = rd1_reg;
	assign link.summary    = summary_reg;
	assign link.irq        = irq_reg;

endmodule : pec_counters

// ==== verilog/pec_firmware.sv ====
// Firmware end: takes APB orders and drives the counter block's internal registers.
// Assumes an APB master on clock_i and the counter block on the other side of the link.
`timescale 1ns/1ns
module pec_firmware (
	// Clock and reset.
	input  wire logic        clock_i,
	input  wire logic        srst_i,
	// APB slave.
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Link to counters.
	pec_if.firmware          link
);

	typedef enum {PEC_IDLE, PEC_INIT0, PEC_INIT1, PEC_INIT2, PEC_INIT3} pec_seq_t;

	// ************************************************************
	// State
	// ************************************************************
	pec_seq_t    seq_reg;
	logic        priv_reg;
	logic        wr_reg;
	logic [2:0]  sel_reg;
	logic [19:0] wdata_reg;
	logic        busy;
	logic        acc;
	logic        mapped;
	logic [19:0] val20;

	assign busy   = (seq_reg != PEC_IDLE);
	assign acc    = psel_i & penable_i & ~busy;
	assign val20  = pwdata_i[19:0];
	assign mapped = (paddr_i <= pec_pkg::OFF_STATUS) && (paddr_i[1:0] == 2'h0);
	assign pready_o  = ~busy;
	assign pslverr_o = psel_i & penable_i & ~busy & ~mapped;

	// ************************************************************
	// Link writes
	// ************************************************************
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			seq_reg   <= PEC_IDLE;
			wr_reg    <= 1'b0;
			sel_reg   <= pec_pkg::IPR_CTR0;
			wdata_reg <= pec_pkg::CTR_RESET;
		end else begin
			wr_reg <= 1'b0;
			case (seq_reg)
				PEC_IDLE: begin
					if (acc && pwrite_i) begin
						wr_reg    <= 1'b1;
						wdata_reg <= val20;
						case (paddr_i)
							pec_pkg::OFF_CTR0: begin
								sel_reg   <= pec_pkg::IPR_CTR0;
								wdata_reg <= (val20 > pec_pkg::CTR0_WR_MAX) ?
									pec_pkg::CTR0_WR_MAX : val20;
							end
							pec_pkg::OFF_CTR1: begin
								sel_reg   <= pec_pkg::IPR_CTR1;
								wdata_reg <= (val20 > pec_pkg::CTR1_WR_MAX) ?
									pec_pkg::CTR1_WR_MAX : val20;
							end
							pec_pkg::OFF_CTL:   sel_reg <= pec_pkg::IPR_CTL;
							pec_pkg::OFF_ICTL:  sel_reg <= pec_pkg::IPR_ICTL;
							pec_pkg::OFF_PROCESS_CONTEXT:  sel_reg <= pec_pkg::IPR_PROCESS_CONTEXT;
							pec_pkg::OFF_IER:   sel_reg <= pec_pkg::IPR_IER;
							pec_pkg::OFF_HWCLR: sel_reg <= pec_pkg::IPR_HWCLR;
							pec_pkg::OFF_CMD: begin
								sel_reg   <= pec_pkg::IPR_CTR1;
								wdata_reg <= pec_pkg::CTR_RESET;
								wr_reg    <= pwdata_i[pec_pkg::CMD_COLLECT_BIT];
								if (pwdata_i[pec_pkg::CMD_INIT_BIT]) begin
									sel_reg <= pec_pkg::IPR_CTR0;
									wr_reg  <= 1'b1;
									seq_reg <= PEC_INIT0;
								end
							end
							default: wr_reg <= 1'b0;
						endcase
					end
				end
				PEC_INIT0: begin
					wr_reg  <= 1'b1;
					sel_reg <= pec_pkg::IPR_CTR1;
					seq_reg <= PEC_INIT1;
				end
				PEC_INIT1: begin
					wr_reg  <= 1'b1;
					sel_reg <= pec_pkg::IPR_CTR0;
					seq_reg <= PEC_INIT2;
				end
				PEC_INIT2: begin
					wr_reg  <= 1'b1;
					sel_reg <= pec_pkg::IPR_CTR1;
					seq_reg <= PEC_INIT3;
				end
				PEC_INIT3: seq_reg <= PEC_IDLE;
				default:   seq_reg <= PEC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			priv_reg <= pec_pkg::PRIV_RESET;
		end else if (acc && pwrite_i && paddr_i == pec_pkg::OFF_PRIV) begin
			priv_reg <= pwdata_i[0];
		end
	end

	// ************************************************************
	// APB read data
	// ************************************************************
	always_comb begin
		prdata_o = 32'h0000_0000;
		case (paddr_i)
			pec_pkg::OFF_CTR0:   prdata_o = {12'h000, link.ctr0_rdata};
			pec_pkg::OFF_CTR1:   prdata_o = {12'h000, link.ctr1_rdata};
			pec_pkg::OFF_PRIV:   prdata_o = {31'h0000_0000, priv_reg};
			pec_pkg::OFF_STATUS: prdata_o = {28'h000_0000, link.irq, busy, link.summary};
			default:             prdata_o = 32'h0000_0000;
		endcase
	end

	assign link.ipr_wr    = wr_reg;
	assign link.ipr_sel   = sel_reg;
	assign link.ipr_wdata = wdata_reg;
	assign link.priv_mode = priv_reg;

endmodule : pec_firmware

// ==== testbench/pec_properties.sv ====
// Checker for the link between the counter block and its firmware end.
// Assumes it sits beside the link interface with every signal wired by name.
`timescale 1ns/1ns
module pec_properties (
	// Clock and reset.
	input wire logic        clock_i,
	input wire logic        srst_i,
	// Link signals.
	input wire logic        ipr_wr,
	input wire logic [2:0]  ipr_sel,
	input wire logic [19:0] ipr_wdata,
	input wire logic        priv_mode,
	input wire logic [19:0] ctr0_rdata,
	input wire logic [19:0] ctr1_rdata,
	input wire logic [1:0]  summary,
	input wire logic        irq
);
	// ************************************************************
	// Shadow of the settings written over the link
	// ************************************************************
	logic [2:0] en_reg;
	logic       proc_reg;
	logic [2:0] ctl_reg;
	logic       ier_reg;
	logic [2:0] quiet_reg;
	logic       live;
	logic       on0;
	logic       on1;
	logic       off1;

	default clocking @(posedge clock_i); endclocking
	default disable iff (srst_i);

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			en_reg   <= 3'h0;
			proc_reg <= 1'b0;
			ctl_reg  <= 3'h0;
			ier_reg  <= 1'b0;
		end else if (ipr_wr) begin
			if (ipr_sel == pec_pkg::IPR_ICTL) en_reg <= ipr_wdata[2:0];
			if (ipr_sel == pec_pkg::IPR_PROCESS_CONTEXT) proc_reg <= ipr_wdata[0];
			if (ipr_sel == pec_pkg::IPR_CTL) ctl_reg <= ipr_wdata[4:2];
			if (ipr_sel == pec_pkg::IPR_IER) ier_reg <= ipr_wdata[0];
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i || ipr_wr) begin
			quiet_reg <= 3'h0;
		end else if (quiet_reg != 3'h7) begin
			quiet_reg <= quiet_reg + 3'h1;
		end
	end

	assign live = (en_reg[0] || proc_reg) && !ctl_reg[2] && quiet_reg > 3'h4;
	assign on0  = live && en_reg[1];
	assign on1  = live && en_reg[2];
	assign off1 = !(en_reg[2] && (en_reg[0] || proc_reg)) && !ctl_reg[2] && quiet_reg > 3'h4;

	// ************************************************************
	// Properties
	// ************************************************************
	a_priv_blocks_irq: assert property (priv_mode |=> !irq)
		else $error("irq raised in privileged mode");
	a_irq_follows_sum: assert property ((summary != 2'h0) && !priv_mode |=> irq)
		else $error("irq missing after summary");
	a_irq_has_cause: assert property (irq |-> $past(summary) != 2'h0 && !$past(priv_mode))
		else $error("irq without cause");
	a_sum_sticky: assert property ((($past(summary) & ~summary) != 2'h0) |->
		$past(ipr_wr) && $past(ipr_sel) == pec_pkg::IPR_HWCLR)
		else $error("summary dropped without clear");
	a_wr0_range: assert property (ipr_wr && ipr_sel == pec_pkg::IPR_CTR0 |->
		ipr_wdata <= pec_pkg::CTR0_WR_MAX) else $error("counter zero write out of range");
	a_wr1_range: assert property (ipr_wr && ipr_sel == pec_pkg::IPR_CTR1 |->
		ipr_wdata <= pec_pkg::CTR1_WR_MAX) else $error("counter one write out of range");
	a_ctr0_echo: assert property (ipr_wr && ipr_sel == pec_pkg::IPR_CTR0 |->
		##2 (ctr0_rdata - $past(ipr_wdata, 2)) <= 20'h4) else $error("counter zero write lost");
	a_step_one: assert property (on1 && ctl_reg[1:0] == 2'h0 |->
		ctr1_rdata == $past(ctr1_rdata) + 20'h1) else $error("cycle count step wrong");
	a_step_zero: assert property (on0 && ctl_reg[0] |->
		ctr0_rdata == $past(ctr0_rdata) + 20'h1) else $error("counter zero cycle step wrong");
	a_idle_hold: assert property (off1 |->
		(ctr1_rdata - $past(ctr1_rdata, 2) + 20'h1) <= 20'h2) else $error("disabled counter moved");
	a_wrap_flag: assert property (on0 && ctl_reg[0] && ier_reg && ctr0_rdata == 20'h0 &&
		$past(ctr0_rdata) == pec_pkg::CTR_MAX |-> summary[0]) else $error("wrap not flagged");
endmodule : pec_properties

// ==== testbench/testbench.sv ====
// Self-checking bench: drives APB and processor events, checks reads against queued notes.
// Assumes the package, the link interface and both design ends are compiled first.
`timescale 1ns/1ns
`define CHK(got, exp) begin \
	compares++; \
	if ((got) !== (exp)) begin \
		fail_count++; \
		$display("unexpected at %0t: got %h want %h", $time, (got), (exp)); \
	end \
end
module testbench;
	// ************************************************************
	// Signals and instances
	// ************************************************************
	logic        clock_i = 1'b0;
	logic        srst_i  = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h0;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [10:0] ret_v   = 11'h0;
	logic [10:0] ret_s   = 11'h0;
	logic [3:0]  fet_v   = 4'h0;
	logic [3:0]  fet_c   = 4'h0;
	logic        miss    = 1'b0;
	logic        replay  = 1'b0;
	logic [15:0] rnd     = 16'hCA6E;
	logic [32:0] note;
	logic [32:0] exp_q[$];
	int          fail_count = 0;
	int          compares   = 0;
	int          ret_sum, fet_sum, miss_sum, rep_sum;

	pec_if link_if ();
	pec_counters pec_counters_inst (.clock_i(clock_i), .srst_i(srst_i), .link(link_if),
		.retire_valid_i(ret_v), .retire_squash_i(ret_s), .fetch_valid_i(fet_v),
		.fetch_conditional_move_i(fet_c), .bcache_miss_i(miss), .replay_trap_i(replay));
	pec_firmware pec_firmware_inst (.clock_i(clock_i), .srst_i(srst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .link(link_if));
	pec_properties pec_properties_inst (.clock_i(clock_i), .srst_i(srst_i),
		.ipr_wr(link_if.ipr_wr), .ipr_sel(link_if.ipr_sel), .ipr_wdata(link_if.ipr_wdata),
		.priv_mode(link_if.priv_mode), .ctr0_rdata(link_if.ctr0_rdata),
		.ctr1_rdata(link_if.ctr1_rdata), .summary(link_if.summary), .irq(link_if.irq));

	always #10 clock_i = ~clock_i;

	// ************************************************************
	// Tasks
	// ************************************************************
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		@(posedge clock_i);
		while (pready !== 1'b1) @(posedge clock_i);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic burst(input int n);
		logic [10:0] v;
		logic [10:0] s;
		{ret_sum, fet_sum, miss_sum, rep_sum} = '0;
		repeat (n) begin
			@(posedge clock_i);
			rnd = lfsr(lfsr(rnd));
			v = rnd[10:0] | 11'h0F0;
			s = v & {rnd[4:0], rnd[15:10]} & {rnd[8:0], rnd[15:14]};
			ret_v  <= v;
			ret_s  <= s;
			fet_v  <= rnd[15:12];
			fet_c  <= rnd[15:12] & rnd[3:0];
			miss   <= rnd[5];
			replay <= rnd[7];
			ret_sum  += $countones(v & ~s);
			fet_sum  += $countones(rnd[15:12]) + $countones(rnd[15:12] & rnd[3:0]);
			miss_sum += rnd[5];
			rep_sum  += rnd[7];
		end
		@(posedge clock_i);
		{ret_v, ret_s, fet_v, fet_c, miss, replay} <= '0;
	endtask : burst

	task automatic run(input logic [31:0] ctl, input logic [31:0] ictl, input logic [31:0] process_context);
		wr(pec_pkg::OFF_CTL, ctl);
		wr(pec_pkg::OFF_PROCESS_CONTEXT, process_context);
		wr(pec_pkg::OFF_CMD, 32'h1);
		wr(pec_pkg::OFF_ICTL, ictl);
		repeat (4) @(posedge clock_i);
		burst(40);
		repeat (30) @(posedge clock_i);
		wr(pec_pkg::OFF_ICTL, 32'h0);
		repeat (4) @(posedge clock_i);
	endtask : run

	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out

	// ************************************************************
	// Read monitor, watchdog and main sequence
	// ************************************************************
	always @(posedge clock_i) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			note = exp_q.pop_front();
			`CHK({pslverr, prdata}, note)
		end
	end

	initial begin
		repeat (20000) @(posedge clock_i);
		fail_count++;
		close_out();
	end

	initial begin
		repeat (8) @(posedge clock_i);
		srst_i <= 1'b0;
		rd(pec_pkg::OFF_STATUS, 33'h0);
		rd(pec_pkg::OFF_PRIV, 33'h1);
		rd(pec_pkg::OFF_CTR0, 33'h0);
		rd(8'h30, 33'h1_0000_0000);
		rd(8'h02, 33'h1_0000_0000);
		wr(pec_pkg::OFF_CTR0, 32'h000F_FFFF);
		wr(pec_pkg::OFF_CTR1, 32'h000F_FFFF);
		wr(pec_pkg::OFF_CTL, 32'h8);
		rd(pec_pkg::OFF_CTR0, 33'h0_000F_FFF0);
		rd(pec_pkg::OFF_CTR1, 33'h0_000F_FFFC);
		wr(pec_pkg::OFF_CMD, 32'h1);
		rd(pec_pkg::OFF_CTR0, 33'h0);
		rd(pec_pkg::OFF_CTR1, 33'h0);
		wr(pec_pkg::OFF_CTR1, 32'h5);
		wr(pec_pkg::OFF_CMD, 32'h2);
		rd(pec_pkg::OFF_CTR1, 33'h0);
		$display("test writes done");
		run(32'h0, 32'h6, 32'h1);
		rd(pec_pkg::OFF_CTR0, {13'h0, 20'(ret_sum)});
		run(32'h8, 32'h7, 32'h0);
		rd(pec_pkg::OFF_CTR0, {13'h0, 20'(ret_sum)});
		rd(pec_pkg::OFF_CTR1, {13'h0, 20'(miss_sum)});
		run(32'hC, 32'h7, 32'h0);
		rd(pec_pkg::OFF_CTR1, {13'h0, 20'(rep_sum)});
		run(32'h8, 32'h6, 32'h0);
		rd(pec_pkg::OFF_CTR0, 33'h0);
		rd(pec_pkg::OFF_CTR1, 33'h0);
		run(32'h10, 32'h7, 32'h0);
		rd(pec_pkg::OFF_CTR0, {13'h0, 20'(fet_sum)});
		$display("test modes done");
		wr(pec_pkg::OFF_CTR0, 32'h000F_FFF0);
		wr(pec_pkg::OFF_IER, 32'h1);
		wr(pec_pkg::OFF_CTL, 32'h4);
		wr(pec_pkg::OFF_ICTL, 32'h3);
		repeat (30) @(posedge clock_i);
		rd(pec_pkg::OFF_STATUS, 33'h1);
		wr(pec_pkg::OFF_PRIV, 32'h0);
		rd(pec_pkg::OFF_STATUS, 33'h9);
		wr(pec_pkg::OFF_HWCLR, 32'h1);
		rd(pec_pkg::OFF_STATUS, 33'h0);
		wr(pec_pkg::OFF_PRIV, 32'h1);
		wr(pec_pkg::OFF_ICTL, 32'h0);
		$display("test overflow done");
		wr(pec_pkg::OFF_CTL, 32'h8);
		wr(pec_pkg::OFF_CTR1, 32'h000F_FFFC);
		wr(pec_pkg::OFF_ICTL, 32'h5);
		wr(pec_pkg::OFF_IER, 32'h2);
		repeat (3) begin
			@(posedge clock_i);
			miss <= 1'b1;
		end
		@(posedge clock_i);
		miss <= 1'b0;
		repeat (4) @(posedge clock_i);
		rd(pec_pkg::OFF_CTR1, 33'h0_000F_FFFF);
		wr(pec_pkg::OFF_CTR1, 32'h0);
		rd(pec_pkg::OFF_STATUS, 33'h0);
		wr(pec_pkg::OFF_PRIV, 32'h0);
		rd(pec_pkg::OFF_STATUS, 33'hA);
		wr(pec_pkg::OFF_HWCLR, 32'h2);
		wr(pec_pkg::OFF_PRIV, 32'h1);
		wr(pec_pkg::OFF_ICTL, 32'h0);
		wr(pec_pkg::OFF_CTL, 32'h0);
		wr(pec_pkg::OFF_CTR0, 32'h100);
		ret_v <= 11'h7FF;
		rd(pec_pkg::OFF_CTR0, 33'h104);
		ret_v <= 11'h000;
		$display("test latch done");
		close_out();
	end
endmodule : testbench
